// ### cdo_settings.v
// Overview of operation
// - polarity and pin select come from F6H
// - emphasis pin normal or inverted
// - channel clock pin normal or inverted
// - select bits route word/frame clock out
// - F7H attenuation on/off, amounts from FAH/FBH
// - mono or stereo from mono bit
// - two-bit PLL sync window width
// - PWM off holds plus high, minus low
// - F8H changes no setting or pointer
// - commands other than F2H, F5H and F8H reload readout pointer
// - FAH parameter sets left attenuation
// - FBH parameter sets right attenuation
// - FCH two-bit error correction select
// - FCH subcode sync guard on/off
// - FCH two-bit forced mute time
// - FCH bilingual right/left select pair
// - FCH digital audio transmit enable
// - FDH clock precision into channel status
// - FDH source number into channel status
// - channel status affects only its outputs
`timescale 1ns/1ps
`default_nettype none
`include "cdo_map.vh"

module cdo_settings (
   input wire core_clk_in,
   input wire rstn_in,
   // register port
   input wire [3:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output wire [7:0] rdata_out,
   // raw signals from the core
   input wire emphasis_flag_in,
   input wire chanclk_in,
   input wire word_clock_signal_in,
   input wire write_frame_clock_signal_in,
   input wire hold_mirror_in,
   input wire pwm_l_in,
   input wire pwm_r_in,
   // conditioned pins
   output wire emphasis_flag_pin_out,
   output wire left_right_channel_clock_pin_out,
   output wire hold_mirror_pin_out,
   output wire pwm_lp_out,
   output wire pwm_ln_out,
   output wire pwm_rp_out,
   output wire pwm_rn_out,
   // settings towards the audio path
   output wire attenuation_enable_bit_out,
   output wire mono_select_bit_out,
   output wire [1:0] sync_window_width_field_out,
   output wire pwm_enable_out,
   output wire [7:0] attn_left_out,
   output wire [7:0] attn_right_out,
   output wire [1:0] ecc_mode_out,
   output wire sync_guard_out,
   output wire [1:0] mute_time_out,
   output wire bilingual_right_select_out,
   output wire bilingual_left_select_out,
   output wire dai_tx_enable_out,
   output wire [1:0] cbit_clock_acc_out,
   output wire [3:0] cbit_source_out,
   output wire [3:0] qptr_out
);

   // ----------------------------------------
   // decoder states
   // ----------------------------------------
   localparam ST_IDLE = 1'b0; // no command open
   localparam ST_PARM = 1'b1; // waiting for parameter

   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg state_q; // decoder state
   reg state_d; // next decoder state
   reg [7:0] cmd_q; // command awaiting its parameter
   reg [7:0] cmd_d; // next pending command
   reg [3:0] pol_q; // polarity and pin select
   reg [3:0] pol_d; // next polarity byte
   reg [4:0] mode_q; // sound output mode
   reg [4:0] mode_d; // next mode byte
   reg [7:0] attl_q; // left attenuation code
   reg [7:0] attl_d; // next left code
   reg [7:0] attr_q; // right attenuation code
   reg [7:0] attr_d; // next right code
   reg [7:0] prm_q; // correction, guard, mute, bilingual
   reg [7:0] prm_d; // next parameter byte
   reg [5:0] cbit_q; // channel status fields
   reg [5:0] cbit_d; // next channel status
   reg [3:0] qptr_q; // subcode readout pointer
   reg [3:0] qptr_d; // next pointer
   reg orphan_q; // parameter with no open command
   reg orphan_d; // next orphan flag
   reg [7:0] rdata_q; // read data, one cycle late
   reg [7:0] rdata_d; // next read data
   reg emphasis_flag_pin_q; // conditioned emphasis pin
   reg left_right_channel_clock_pin_q; // conditioned channel clock pin
   reg hm_q; // hold/mirror pin
   reg hm_d; // next hold/mirror pin
   reg lp_q; // left plus pwm pin
   reg ln_q; // left minus pwm pin
   reg rp_q; // right plus pwm pin
   reg rn_q; // right minus pwm pin

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire cmd_wr; // command byte arrives
   wire prm_wr; // parameter byte arrives
   wire needs_prm; // written command carries a parameter
   wire keeps_ptr; // command leaves the pointer alone
   assign cmd_wr = wr_in && (addr_in == `CDO_ADR_CMD);
   assign prm_wr = wr_in && (addr_in == `CDO_ADR_PRM);
   assign needs_prm = (wdata_in == `CDO_CMD_QADDR) ||
                      (wdata_in == `CDO_CMD_POL) ||
                      (wdata_in == `CDO_CMD_MODE) ||
                      (wdata_in == `CDO_CMD_ATTL) ||
                      (wdata_in == `CDO_CMD_ATTR) ||
                      (wdata_in == `CDO_CMD_PARAM) ||
                      (wdata_in == `CDO_CMD_CBIT) ||
                      (wdata_in == `CDO_CMD_DATT);
   // readout commands and the no-op keep the pointer
   assign keeps_ptr = (wdata_in == `CDO_CMD_QADDR) ||
                      (wdata_in == `CDO_CMD_QNEXT) ||
                      (wdata_in == `CDO_CMD_NOP);

   // ----------------------------------------
   // command interpreter
   // ----------------------------------------
   // a field changes only when its parameter lands,
   // so the whole byte takes effect in one edge
   always @* begin
      state_d = state_q;
      cmd_d = cmd_q;
      pol_d = pol_q;
      mode_d = mode_q;
      attl_d = attl_q;
      attr_d = attr_q;
      prm_d = prm_q;
      cbit_d = cbit_q;
      qptr_d = qptr_q;
      orphan_d = orphan_q;
      // reading status clears the orphan flag
      if (rd_in && (addr_in == `CDO_ADR_STAT)) begin
         orphan_d = 1'b0;
      end
      case (state_q)
         ST_IDLE: begin
            if (prm_wr) begin
               // stray parameter is dropped, flagged
               orphan_d = 1'b1;
            end
         end
         ST_PARM: begin
            if (prm_wr) begin
               state_d = ST_IDLE;
               case (cmd_q)
                  `CDO_CMD_QADDR: begin
                     qptr_d = wdata_in[3:0];
                  end
                  `CDO_CMD_POL: begin
                     pol_d = wdata_in[3:0];
                  end
                  `CDO_CMD_MODE: begin
                     mode_d = wdata_in[4:0];
                  end
                  `CDO_CMD_ATTL: begin
                     attl_d = wdata_in;
                  end
                  `CDO_CMD_ATTR: begin
                     attr_d = wdata_in;
                  end
                  `CDO_CMD_PARAM: begin
                     prm_d = wdata_in;
                  end
                  `CDO_CMD_CBIT: begin
                     cbit_d = wdata_in[5:0];
                  end
                  default: begin
                     // digital attenuation byte swallowed
                     state_d = ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // a new command abandons an open one
      if (cmd_wr) begin
         cmd_d = wdata_in;
         state_d = needs_prm ? ST_PARM : ST_IDLE;
         if (!keeps_ptr) begin
            qptr_d = `CDO_RST_QPTR;
         end
         // the no-op touches nothing else
         if (wdata_in == `CDO_CMD_NOP) begin
            state_d = ST_IDLE;
         end
      end
   end

   // ----------------------------------------
   // setting registers
   // ----------------------------------------
   // attenuation codes are undefined after reset
   // by the device; mute is the safe choice here
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= ST_IDLE;
         cmd_q <= 8'h00;
         pol_q <= `CDO_RST_POL;
         mode_q <= `CDO_RST_MODE;
         attl_q <= `CDO_RST_ATT;
         attr_q <= `CDO_RST_ATT;
         prm_q <= `CDO_RST_PARAM;
         cbit_q <= `CDO_RST_CBIT;
         qptr_q <= `CDO_RST_QPTR;
         orphan_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         pol_q <= pol_d;
         mode_q <= mode_d;
         attl_q <= attl_d;
         attr_q <= attr_d;
         prm_q <= prm_d;
         cbit_q <= cbit_d;
         qptr_q <= qptr_d;
         orphan_q <= orphan_d;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   // data shows in the cycle after the strobe only;
   // unmapped addresses answer zero
   always @* begin
      rdata_d = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `CDO_ADR_CMD: begin
               rdata_d = cmd_q;
            end
            `CDO_ADR_POL: begin
               rdata_d = {4'h0, pol_q};
            end
            `CDO_ADR_MODE: begin
               rdata_d = {3'h0, mode_q};
            end
            `CDO_ADR_ATTL: begin
               rdata_d = attl_q;
            end
            `CDO_ADR_ATTR: begin
               rdata_d = attr_q;
            end
            `CDO_ADR_PARAM: begin
               rdata_d = prm_q;
            end
            `CDO_ADR_CBIT: begin
               rdata_d = {2'h0, cbit_q};
            end
            `CDO_ADR_STAT: begin
               rdata_d = {2'h0, orphan_q, state_q, qptr_q};
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // hold/mirror pin select
   // ----------------------------------------
   // code 0 keeps the hold/mirror signal,
   // 1 word clock, 2 and 3 frame clock
   always @* begin
      case (pol_q[`CDO_POL_PS_HI:`CDO_POL_PS_LO])
         2'h0: begin
            hm_d = hold_mirror_in;
         end
         2'h1: begin
            hm_d = word_clock_signal_in;
         end
         default: begin
            hm_d = write_frame_clock_signal_in;
         end
      endcase
   end

   // ----------------------------------------
   // pin conditioning
   // ----------------------------------------
   // every pin is registered, so it trails the
   // source by one clock; polarity is software's
   // job to keep at zero with the on-chip converter
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         emphasis_flag_pin_q <= 1'b0;
         left_right_channel_clock_pin_q <= 1'b0;
         hm_q <= 1'b0;
         lp_q <= 1'b1;
         ln_q <= 1'b0;
         rp_q <= 1'b1;
         rn_q <= 1'b0;
      end else begin
         emphasis_flag_pin_q <= emphasis_flag_in ^ pol_q[`CDO_POL_EP];
         left_right_channel_clock_pin_q <= chanclk_in ^ pol_q[`CDO_POL_LP];
         hm_q <= hm_d;
         if (mode_q[`CDO_MODE_PWM]) begin
            // differential pair from the modulator
            lp_q <= pwm_l_in;
            ln_q <= ~pwm_l_in;
            rp_q <= pwm_r_in;
            rn_q <= ~pwm_r_in;
         end else begin
            // parked: plus high, minus low
            lp_q <= 1'b1;
            ln_q <= 1'b0;
            rp_q <= 1'b1;
            rn_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rdata_out = rdata_q;
   assign emphasis_flag_pin_out = emphasis_flag_pin_q;
   assign left_right_channel_clock_pin_out = left_right_channel_clock_pin_q;
   assign hold_mirror_pin_out = hm_q;
   assign pwm_lp_out = lp_q;
   assign pwm_ln_out = ln_q;
   assign pwm_rp_out = rp_q;
   assign pwm_rn_out = rn_q;
   // sound mode fields
   assign attenuation_enable_bit_out = mode_q[`CDO_MODE_AT2];
   assign mono_select_bit_out = mode_q[`CDO_MODE_MON];
   assign sync_window_width_field_out = mode_q[`CDO_MODE_WD_HI:`CDO_MODE_WD_LO];
   assign pwm_enable_out = mode_q[`CDO_MODE_PWM];
   // attenuation amounts, 00 is full mute
   assign attn_left_out = attl_q;
   assign attn_right_out = attr_q;
   // parameter setting fields
   assign ecc_mode_out = prm_q[`CDO_PRM_E_HI:`CDO_PRM_E_LO];
   assign sync_guard_out = prm_q[`CDO_PRM_S];
   assign mute_time_out = prm_q[`CDO_PRM_T_HI:`CDO_PRM_T_LO];
   assign bilingual_right_select_out = prm_q[`CDO_PRM_BR];
   assign bilingual_left_select_out = prm_q[`CDO_PRM_BL];
   assign dai_tx_enable_out = prm_q[`CDO_PRM_TX];
   // channel status leaves the block on these and the read port
   assign cbit_clock_acc_out = cbit_q[`CDO_CB_C_HI:`CDO_CB_C_LO];
   assign cbit_source_out = cbit_q[`CDO_CB_S_HI:`CDO_CB_S_LO];
   assign qptr_out = qptr_q;

endmodule // cdo_settings
`default_nettype wire

// ### cdo_map.vh
`ifndef CDO_MAP_VH
`define CDO_MAP_VH
// ----------------------------------------
// command bytes
// ----------------------------------------
`define CDO_CMD_QADDR 8'hF2
`define CDO_CMD_QNEXT 8'hF5
`define CDO_CMD_POL 8'hF6
`define CDO_CMD_MODE 8'hF7
`define CDO_CMD_NOP 8'hF8
`define CDO_CMD_ATTL 8'hFA
`define CDO_CMD_ATTR 8'hFB
`define CDO_CMD_PARAM 8'hFC
`define CDO_CMD_CBIT 8'hFD
`define CDO_CMD_DATT 8'hFE
// ----------------------------------------
// port addresses
// ----------------------------------------
`define CDO_ADR_CMD 4'h0
`define CDO_ADR_PRM 4'h1
`define CDO_ADR_POL 4'h2
`define CDO_ADR_MODE 4'h3
`define CDO_ADR_ATTL 4'h4
`define CDO_ADR_ATTR 4'h5
`define CDO_ADR_PARAM 4'h6
`define CDO_ADR_CBIT 4'h7
`define CDO_ADR_STAT 4'h8
// ----------------------------------------
// field positions
// ----------------------------------------
`define CDO_POL_EP 0
`define CDO_POL_LP 1
`define CDO_POL_PS_LO 2
`define CDO_POL_PS_HI 3
`define CDO_MODE_PWM 0
`define CDO_MODE_WD_LO 1
`define CDO_MODE_WD_HI 2
`define CDO_MODE_MON 3
`define CDO_MODE_AT2 4
`define CDO_PRM_E_LO 0
`define CDO_PRM_E_HI 1
`define CDO_PRM_S 2
`define CDO_PRM_T_LO 3
`define CDO_PRM_T_HI 4
`define CDO_PRM_BL 5
`define CDO_PRM_BR 6
`define CDO_PRM_TX 7
`define CDO_CB_C_LO 0
`define CDO_CB_C_HI 1
`define CDO_CB_S_LO 2
`define CDO_CB_S_HI 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define CDO_RST_POL 4'h0
`define CDO_RST_MODE 5'h00
`define CDO_RST_ATT 8'h00
`define CDO_RST_PARAM 8'h00
`define CDO_RST_CBIT 6'h00
`define CDO_RST_QPTR 4'hA
`endif

// ### cdo_settings_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdo_map.vh"
// ----------------------------------------
// port-level checker of the settings block
// ----------------------------------------
module cdo_settings_sva (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic pwm_l_in,
   input wire logic pwm_lp_out,
   input wire logic pwm_ln_out,
   input wire logic pwm_rp_out,
   input wire logic pwm_rn_out,
   input wire logic pwm_enable_out,
   input wire logic attenuation_enable_bit_out,
   input wire logic mono_select_bit_out,
   input wire logic [1:0] sync_window_width_field_out,
   input wire logic [7:0] attn_left_out,
   input wire logic [7:0] attn_right_out,
   input wire logic [3:0] qptr_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   // command byte taken this cycle
   wire logic cmd_wr = wr_in && addr_in == `CDO_ADR_CMD;
   // parameter byte taken this cycle
   wire logic prm_wr = wr_in && addr_in == `CDO_ADR_PRM;
   // mode, attenuation and pointer settings seen at the ports, for the stability check
   wire logic [24:0] all_set = {attn_left_out, attn_right_out, qptr_out, pwm_enable_out,
      attenuation_enable_bit_out, mono_select_bit_out, sync_window_width_field_out};
   // pins judged against last cycle's enable, since they lag one edge
   property p_pwm_off;
      !$past(pwm_enable_out) |-> pwm_lp_out && !pwm_ln_out && pwm_rp_out && !pwm_rn_out;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("pwm pins not parked");
   property p_pwm_on;
      $past(pwm_enable_out) |-> pwm_lp_out == $past(pwm_l_in) && pwm_ln_out == !$past(pwm_l_in);
   endproperty
   a_pwm_on: assert property (p_pwm_on) else $error("pwm pins not following");
   property p_rd_left;
      $past(rd_in) && $past(addr_in) == `CDO_ADR_ATTL |-> rdata_out == $past(attn_left_out);
   endproperty
   a_rd_left: assert property (p_rd_left) else $error("left amount read wrong");
   property p_rd_right;
      $past(rd_in) && $past(addr_in) == `CDO_ADR_ATTR |-> rdata_out == $past(attn_right_out);
   endproperty
   a_rd_right: assert property (p_rd_right) else $error("right amount read wrong");
   // no checked setting moves without a write
   property p_hold;
      !$past(wr_in) |-> $stable(all_set);
   endproperty
   a_hold: assert property (p_hold) else $error("setting moved without write");
   property p_mode;
      prm_wr && $past(cmd_wr && wdata_in == `CDO_CMD_MODE) |=> {attenuation_enable_bit_out,
         mono_select_bit_out, sync_window_width_field_out, pwm_enable_out} == $past(wdata_in[4:0]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode fields wrong");
   property p_att_l;
      prm_wr && $past(cmd_wr && wdata_in == `CDO_CMD_ATTL) |=> attn_left_out == $past(wdata_in);
   endproperty
   a_att_l: assert property (p_att_l) else $error("left amount not loaded");
   property p_nop;
      cmd_wr && wdata_in == `CDO_CMD_NOP |=> $stable(all_set);
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed a setting");
   property p_ptr;
      cmd_wr && !(wdata_in inside {`CDO_CMD_QADDR, `CDO_CMD_QNEXT, `CDO_CMD_NOP})
         |=> qptr_out == `CDO_RST_QPTR;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer not reloaded");
endmodule // cdo_settings_sva
`default_nettype wire

// ### cdo_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdo_map.vh"
// ----------------------------------------
// controller model driving the byte port
// ----------------------------------------
module cdo_host (
   input wire logic core_clk_in,
   input wire logic [7:0] rdata_in,
   output logic [3:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 4'h0;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // one write cycle, strobe left high so writes can run back to back
   task put(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      rd_out <= 1'b0;
   endtask
   // strobes down, data scrambled so stale bytes never look valid
   task idle;
      @(posedge core_clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      wdata_out <= ~wdata_out;
   endtask
   // command byte then its parameter, no gap
   task cmd(input logic [7:0] c, input logic [7:0] p);
      put(`CDO_ADR_CMD, c);
      put(`CDO_ADR_PRM, p);
   endtask
   // read: data stands only in the cycle after the strobe
   task get(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      wr_out <= 1'b0;
      @(posedge core_clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask
endmodule // cdo_host
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdo_map.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
// ----------------------------------------
// self-checking bench of the settings block
// ----------------------------------------
module tb_top;
   logic core_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [6:0] pat = 7'h00; // free-running source of core signals
   logic [6:0] p1; // core signals as seen before the last edge
   logic [7:0] rv;
   int errors = 0;
   int comparisons = 0;
   wire [3:0] addr_in;
   wire [7:0] wdata_in, rdata_out, attn_left_out, attn_right_out;
   wire wr_in, rd_in;
   wire emphasis_flag_in = pat[0];
   wire chanclk_in = pat[1];
   wire word_clock_signal_in = pat[2];
   wire write_frame_clock_signal_in = pat[3];
   wire hold_mirror_in = pat[4];
   wire pwm_l_in = pat[0] ^ pat[1];
   wire pwm_r_in = pat[2];
   wire emphasis_flag_pin_out, left_right_channel_clock_pin_out, hold_mirror_pin_out;
   wire pwm_lp_out, pwm_ln_out, pwm_rp_out, pwm_rn_out, pwm_enable_out;
   wire attenuation_enable_bit_out, mono_select_bit_out, sync_guard_out, dai_tx_enable_out;
   wire bilingual_right_select_out, bilingual_left_select_out;
   wire [1:0] sync_window_width_field_out, ecc_mode_out, mute_time_out, cbit_clock_acc_out;
   wire [3:0] cbit_source_out, qptr_out;
   always #10 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) pat <= pat + 7'h01;
   cdo_settings cdo_settings_i (.*);
   cdo_host cdo_host_i (.core_clk_in(core_clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
      .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task tick;
      @(posedge core_clk_in);
      #1;
      p1 = pat - 7'h01;
   endtask
   task done;
      cdo_host_i.idle;
      #1;
      p1 = pat - 7'h01;
   endtask
   task complete_run;
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      tick;
      `CHK(qptr_out, `CDO_RST_QPTR)
      `CHK({pwm_enable_out, pwm_lp_out, pwm_ln_out, pwm_rp_out, pwm_rn_out}, 5'b01010)
      `CHK({ecc_mode_out, mute_time_out, cbit_source_out, dai_tx_enable_out}, 9'h000)
   endtask
   // amounts loaded before attenuation is switched on
   task t_att;
      cdo_host_i.cmd(`CDO_CMD_ATTL, 8'hFF);
      cdo_host_i.cmd(`CDO_CMD_ATTR, 8'h00);
      cdo_host_i.put(`CDO_ADR_PRM, 8'h12); // orphan byte, must be dropped
      done;
      `CHK({attn_left_out, attn_right_out}, 16'hFF00)
      cdo_host_i.get(`CDO_ADR_ATTR, rv);
      `CHK(rv, 8'h00)
      cdo_host_i.get(`CDO_ADR_ATTL, rv);
      `CHK(rv, 8'hFF)
      cdo_host_i.get(`CDO_ADR_STAT, rv);
      `CHK(rv, 8'h2A)
      cdo_host_i.get(`CDO_ADR_STAT, rv);
      `CHK(rv, 8'h0A)
   endtask
   // every window width, mono and pwm both ways
   task t_mode;
      logic [7:0] v [4] = '{8'h1F, 8'h0A, 8'h15, 8'h00};
      for (int i = 0; i < 4; i++) begin
         cdo_host_i.cmd(`CDO_CMD_MODE, v[i]);
         done;
         `CHK({attenuation_enable_bit_out, mono_select_bit_out, sync_window_width_field_out,
            pwm_enable_out}, v[i][4:0])
         tick;
         `CHK({pwm_lp_out, pwm_ln_out, pwm_rp_out, pwm_rn_out}, v[i][0] ?
            {p1[0] ^ p1[1], ~(p1[0] ^ p1[1]), p1[2], ~p1[2]} : 4'b1010)
      end
   endtask
   // all codes of the correction and mute fields, both bilingual selects
   task t_param;
      logic [7:0] v [5] = '{8'hA5, 8'hFF, 8'h08, 8'h10, 8'h5A};
      for (int i = 0; i < 5; i++) begin
         cdo_host_i.cmd(`CDO_CMD_PARAM, v[i]);
         done;
         `CHK({dai_tx_enable_out, bilingual_right_select_out, bilingual_left_select_out,
            mute_time_out, sync_guard_out, ecc_mode_out}, v[i])
      end
   endtask
   // channel status bits leave transmit enable, correction, left amount and pwm enable alone
   task t_cbit;
      cdo_host_i.cmd(`CDO_CMD_CBIT, 8'h3E);
      done;
      `CHK({cbit_source_out, cbit_clock_acc_out}, 6'h3E)
      `CHK({dai_tx_enable_out, ecc_mode_out, attn_left_out, pwm_enable_out}, 12'h5FE)
      cdo_host_i.cmd(`CDO_CMD_CBIT, 8'h01);
      done;
      `CHK({cbit_source_out, cbit_clock_acc_out}, 6'h01)
   endtask
   // both polarities and all pin selects, polarity left at zero after
   task t_pol;
      logic [7:0] v [5] = '{8'h01, 8'h06, 8'h0B, 8'h0C, 8'h00};
      for (int i = 0; i < 5; i++) begin
         cdo_host_i.cmd(`CDO_CMD_POL, v[i]);
         done;
         tick;
         `CHK(emphasis_flag_pin_out, p1[0] ^ v[i][0])
         `CHK(left_right_channel_clock_pin_out, p1[1] ^ v[i][1])
         `CHK(hold_mirror_pin_out, v[i][3] ? p1[3] : (v[i][2] ? p1[2] : p1[4]))
      end
   endtask
   // pointer kept by readout and no-op commands, reloaded by others
   task t_ptr;
      cdo_host_i.cmd(`CDO_CMD_QADDR, 8'h03);
      cdo_host_i.put(`CDO_ADR_CMD, `CDO_CMD_NOP);
      cdo_host_i.put(`CDO_ADR_CMD, `CDO_CMD_QNEXT);
      done;
      `CHK({qptr_out, attn_left_out, cbit_source_out}, 16'h3FF0)
      cdo_host_i.put(`CDO_ADR_CMD, `CDO_CMD_POL);
      done;
      `CHK(qptr_out, `CDO_RST_QPTR)
      // digital attenuation byte is swallowed, pointer reloaded
      cdo_host_i.cmd(`CDO_CMD_QADDR, 8'h05);
      cdo_host_i.cmd(`CDO_CMD_DATT, 8'h55);
      done;
      `CHK({qptr_out, attn_left_out, attn_right_out}, 20'hAFF00)
      cdo_host_i.get(`CDO_ADR_STAT, rv);
      `CHK(rv, 8'h0A)
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      t_reset;
      t_att;
      t_mode;
      t_param;
      t_cbit;
      t_pol;
      t_ptr;
      complete_run;
   end
   initial begin
      #200000;
      errors++;
      complete_run;
   end
endmodule // tb_top
bind cdo_settings cdo_settings_sva cdo_settings_sva_i (.*);
`default_nettype wire
